// >>> pcfg_top.sv
// port 3 pin configuration and port value registers behind axi4-lite
// assumes one clock, synchronous active-low reset, pins synchronous to aclk
// assumes byte address is four times the register index, data in lane 0
// limitation: illegal output codes are stored as written
//
// Notes on behaviour
// - output code 000 is normal drive, 011 is high drive.
// - bit 4 selects output (0) or input (1) setting.
// - bit 3 set stores pin index and direction for reads.
// - with bit 3 set, function settings stay unchanged.
// - with bit 3 clear, addressed pin setting takes written code.
// - bits 2:0 pick the single pin that is configured.
// - read returns code of stored pin and stored direction.
// - index 0..6 are pins 0..6; index 7 has no pin.
// - one 8-bit value register per port, reset all ones.
// - input codes: none, pull-down, pull-up, buffer off.
`timescale 1ns/1ps
`include "pcfg_params.svh"
module pcfg_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pin levels
  input wire logic [7:0] port0_pins_in,
  input wire logic [7:0] port1_pins_in,
  input wire logic [7:0] port2_pins_in,
  input wire logic [7:0] port3_pins_in,
  output logic [7:0] port0_value_out,
  output logic [7:0] port1_value_out,
  output logic [7:0] port2_value_out,
  output logic [7:0] port3_value_out,
  // port 3 per-pin settings, three output bits and two input bits per pin
  output logic [20:0] port3_out_mode,
  output logic [13:0] port3_in_mode
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // map a byte address to a register index hit; unaligned addresses miss
  function automatic logic addr_is(input logic [31:0] a, input logic [`PCFG_ADDR_W-1:0] idx);
    logic upper_clear;
    logic lane_clear;
    upper_clear = (a[31:`PCFG_ADDR_W+`PCFG_IDX_LSB] == '0);
    lane_clear = (a[`PCFG_IDX_LSB-1:0] == '0);
    addr_is = upper_clear && lane_clear &&
      (a[`PCFG_ADDR_W+`PCFG_IDX_LSB-1:`PCFG_IDX_LSB] == idx);
  endfunction : addr_is

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // port latches and sampled pins
  logic [7:0] port_q [`PCFG_NPORTS];
  logic [7:0] pin_sync_q [`PCFG_NPORTS];
  // pin settings and read pointer
  logic [2:0] out_cfg_q [`PCFG_NPINS];
  logic [1:0] in_cfg_q [`PCFG_NPINS];
  logic [2:0] rd_index_q;
  logic rd_dir_q;
  // axi capture and answer
  logic aw_have_q;
  logic w_have_q;
  logic [31:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  pcfg_pkg::pcfg_wstate_t wstate_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // ready flags, registered
  logic awready_q;
  logic wready_q;
  logic arready_q;

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  // a write runs once address and data are both held and no answer waits
  wire do_write = aw_have_q && w_have_q && (wstate_q == pcfg_pkg::PCFG_W_IDLE);
  wire hit_p0 = addr_is(awaddr_q, `PCFG_OFF_PORT0);
  wire hit_p1 = addr_is(awaddr_q, `PCFG_OFF_PORT1);
  wire hit_p2 = addr_is(awaddr_q, `PCFG_OFF_PORT2);
  wire hit_p3 = addr_is(awaddr_q, `PCFG_OFF_PORT3);
  wire hit_cfg = addr_is(awaddr_q, `PCFG_OFF_P3CFG_IDX);
  // unmapped or unaligned addresses answer with slave error
  wire w_mapped = hit_p0 | hit_p1 | hit_p2 | hit_p3 | hit_cfg;
  // a write with byte lane 0 off is answered but changes nothing
  wire w_en = do_write && wstrb0_q;
  // field split of the configuration write
  wire [2:0] wr_code = wdata_q[`PCFG_F_CODE];  // pin_function_code
  wire wr_dir = wdata_q[`PCFG_F_DIR];  // 0 output, 1 input
  wire wr_ptr_load = wdata_q[`PCFG_F_PTR];  // read_pointer_load
  wire [2:0] wr_index = wdata_q[`PCFG_F_IDX];  // pin_index
  // update only when pointer load is clear
  wire cfg_update = w_en && hit_cfg && !wr_ptr_load;
  // pointer load stores index and direction
  wire ptr_update = w_en && hit_cfg && wr_ptr_load;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  wire r_p0 = addr_is(s_axi_araddr, `PCFG_OFF_PORT0);
  wire r_p1 = addr_is(s_axi_araddr, `PCFG_OFF_PORT1);
  wire r_p2 = addr_is(s_axi_araddr, `PCFG_OFF_PORT2);
  wire r_p3 = addr_is(s_axi_araddr, `PCFG_OFF_PORT3);
  wire r_cfg = addr_is(s_axi_araddr, `PCFG_OFF_P3CFG_IDX);
  // unmapped or unaligned reads answer zero with slave error
  wire r_mapped = r_p0 | r_p1 | r_p2 | r_p3 | r_cfg;
  wire ar_take = s_axi_arvalid && !rvalid_q;
  // index 7 reads as zero, no pin behind it
  wire idx_valid = (rd_index_q != `PCFG_IDX_RSVD);
  // code of stored pin by stored direction
  wire [2:0] rd_out_code = out_cfg_q[rd_index_q];
  wire [2:0] rd_in_code = {1'b0, in_cfg_q[rd_index_q]};
  wire [2:0] rd_sel_code = rd_dir_q ? rd_in_code : rd_out_code;
  wire [2:0] cfg_code = idx_valid ? rd_sel_code : `PCFG_OUT_RST;
  // code sits in bits 7:5, the write-only fields read as zero
  wire [7:0] cfg_rd = {cfg_code, `PCFG_RD_PAD};
  // read data selection: sampled pins or configuration code
  wire [7:0] rd_byte = r_p0 ? pin_sync_q[0] :
    r_p1 ? pin_sync_q[1] :
    r_p2 ? pin_sync_q[2] :
    r_p3 ? pin_sync_q[3] :
    r_cfg ? cfg_rd : 8'h00;

  // ---------------------------------------------------------------
  // handshake next state
  // ---------------------------------------------------------------
  // mirrors the capture and read logic so the ready flops track it
  wire aw_have_d = (s_axi_awvalid && !aw_have_q) || (aw_have_q && !do_write);
  wire w_have_d = (s_axi_wvalid && !w_have_q) || (w_have_q && !do_write);
  wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);

  // ---------------------------------------------------------------
  // axi write channel capture
  // ---------------------------------------------------------------

  // hold address and data until both have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[`PCFG_F_LANE];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= pcfg_pkg::PCFG_W_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= `PCFG_RESP_OKAY;
    end else begin
      case (wstate_q)
        pcfg_pkg::PCFG_W_IDLE: begin
          if (do_write) begin
            wstate_q <= pcfg_pkg::PCFG_W_RESP;
            bvalid_q <= 1'b1;
            bresp_q <= w_mapped ? `PCFG_RESP_OKAY : `PCFG_RESP_SLVERR;
          end
        end
        pcfg_pkg::PCFG_W_RESP: begin
          if (s_axi_bready) begin
            wstate_q <= pcfg_pkg::PCFG_W_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: begin
          wstate_q <= pcfg_pkg::PCFG_W_IDLE;
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // port value registers
  // ---------------------------------------------------------------

  // port values reset to all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `PCFG_NPORTS; i++) begin
        port_q[i] <= `PCFG_PORT_RST;
      end
    end else begin
      // software writes land on the output latch
      if (w_en && hit_p0) port_q[0] <= wdata_q;
      if (w_en && hit_p1) port_q[1] <= wdata_q;
      if (w_en && hit_p2) port_q[2] <= wdata_q;
      if (w_en && hit_p3) port_q[3] <= wdata_q;
    end
  end

  // pins sampled once; a port read shows the level one cycle late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `PCFG_NPORTS; i++) begin
        pin_sync_q[i] <= `PCFG_PORT_RST;
      end
    end else begin
      pin_sync_q[0] <= port0_pins_in;
      pin_sync_q[1] <= port1_pins_in;
      pin_sync_q[2] <= port2_pins_in;
      pin_sync_q[3] <= port3_pins_in;
    end
  end

  // ---------------------------------------------------------------
  // port 3 pin settings
  // ---------------------------------------------------------------

  // all settings and pointer reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `PCFG_NPINS; i++) begin
        out_cfg_q[i] <= `PCFG_OUT_RST;
        in_cfg_q[i] <= `PCFG_IN_RST;
      end
      rd_index_q <= `PCFG_PTR_RST;
      rd_dir_q <= 1'b0;
    end else begin
      if (ptr_update) begin
        rd_index_q <= wr_index;
        rd_dir_q <= wr_dir;
      end
      // index selects one pin; skipped on pointer load
      // index 7 matches no pin, so the write is dropped
      for (int i = 0; i < `PCFG_NPINS; i++) begin
        if (cfg_update && (wr_index == 3'(i))) begin
          if (wr_dir) begin
            // two-bit input code from bits 6:5
            in_cfg_q[i] <= wr_code[`PCFG_F_INCODE];
          end else begin
            out_cfg_q[i] <= wr_code;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------

  // one read at a time, answer the cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PCFG_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= r_mapped ? `PCFG_RESP_OKAY : `PCFG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ready flags kept as flops so every bus output leaves a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      awready_q <= !aw_have_d;
      wready_q <= !w_have_d;
      arready_q <= !rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // write channels
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  // read channels
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // port values
  assign port0_value_out = port_q[0];
  assign port1_value_out = port_q[1];
  assign port2_value_out = port_q[2];
  assign port3_value_out = port_q[3];
  // flatten settings for the pad drivers
  for (genvar g = 0; g < `PCFG_NPINS; g++) begin : g_flat
    assign port3_out_mode[3*g +: 3] = out_cfg_q[g];
    assign port3_in_mode[2*g +: 2] = in_cfg_q[g];
  end

endmodule : pcfg_top

// >>> pcfg_params.svh
// constants for the port 3 pin configuration block
// assumes a 32-bit axi4-lite slave; offsets are register indices, byte address is four times
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
`define PCFG_ADDR_W 8
`define PCFG_OFF_PORT0 8'h80
`define PCFG_OFF_P3CFG_IDX 8'h8f
`define PCFG_OFF_PORT1 8'h90
`define PCFG_OFF_PORT2 8'ha0
`define PCFG_OFF_PORT3 8'hb0
`define PCFG_PORT_RST 8'hff
`define PCFG_CFG_RST 8'h00
`define PCFG_NPINS 7
`define PCFG_IDX_RSVD 3'h7
`define PCFG_RESP_OKAY 2'h0
`define PCFG_RESP_SLVERR 2'h2
`define PCFG_NPORTS 4
`define PCFG_IDX_LSB 2
`define PCFG_F_LANE 7:0
`define PCFG_F_CODE 7:5
`define PCFG_F_INCODE 1:0
`define PCFG_F_DIR 4
`define PCFG_F_PTR 3
`define PCFG_F_IDX 2:0
`define PCFG_OUT_RST 3'h0
`define PCFG_IN_RST 2'h0
`define PCFG_PTR_RST 3'h0
`define PCFG_RD_PAD 5'h00
`endif

// >>> pcfg_pkg.sv
// types for the port 3 pin configuration block
// assumes pcfg_params.svh is available
package pcfg_pkg;
  typedef enum logic [2:0] {
    PCFG_OUT_NORMAL = 3'h0,
    PCFG_OUT_HIGH = 3'h3
  } pcfg_out_mode_t;
  typedef enum logic [1:0] {
    PCFG_IN_NOPULL = 2'h0,
    PCFG_IN_PULLDOWN = 2'h1,
    PCFG_IN_PULLUP = 2'h2,
    PCFG_IN_OFF = 2'h3
  } pcfg_in_mode_t;
  typedef enum logic [1:0] {
    PCFG_W_IDLE = 2'b00,
    PCFG_W_RESP = 2'b01
  } pcfg_wstate_t;
endpackage : pcfg_pkg

// >>> pcfg_top_chk.sv
// assertions on the port 3 pin configuration block
// assumes binding into pcfg_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
module pcfg_top_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // pin side
  input wire logic [7:0] port0_value_out,
  input wire logic [20:0] port3_out_mode,
  input wire logic [13:0] port3_in_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken at once, and that aimed at the config register
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // config register index 0x8f sits at byte address 0x23c
  wire cfg_go = wr_go && (s_axi_awaddr == 32'h0000023c);
  AST_CFG_RST: assert property ($rose(aresetn) |-> port3_out_mode == 21'h0)
    else $error("output codes not cleared by reset");
  AST_PORT_RST: assert property ($rose(aresetn) |-> port0_value_out == 8'hff)
    else $error("port value not all ones after reset");
  AST_OUT_WR: assert property (cfg_go && s_axi_wdata[7:0] == 8'h60 |->
    ##[1:2] port3_out_mode[2:0] == 3'h3) else $error("pin 0 output code not stored");
  AST_IN_WR: assert property (cfg_go && s_axi_wdata[7:0] == 8'h51 |->
    ##[1:2] port3_in_mode[3:2] == 2'h2) else $error("pin 1 input code not stored");
  AST_PTR_KEEP: assert property (cfg_go && s_axi_wdata[3] |=>
    ($stable(port3_out_mode) && $stable(port3_in_mode)) [*2]) else $error("pointer load moved codes");
  AST_RSVD: assert property (cfg_go && s_axi_wdata[2:0] == 3'h7 |=>
    ($stable(port3_out_mode) && $stable(port3_in_mode)) [*2]) else $error("index 7 moved codes");
  AST_B_LAT: assert property (wr_go |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("no read data");
  AST_AR_HOLD: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // main scenarios
  COV_PTR: cover property (cfg_go && s_axi_wdata[3]);
  COV_RSVD: cover property (cfg_go && s_axi_wdata[2:0] == 3'h7);
  COV_RD: cover property (s_axi_rvalid && s_axi_rdata[7:5] == 3'h3);
endmodule : pcfg_top_chk
bind pcfg_top pcfg_top_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_wdata, .s_axi_rdata,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .port0_value_out, .port3_out_mode,
  .port3_in_mode);

// >>> pcfg_pin_load.sv
// external load on one port: pins read back the driven level, some bits inverted
// assumes levels settle within one aclk cycle
`timescale 1ns/1ps
module pcfg_pin_load #(
  parameter logic [7:0] FLIP = 8'h0f
) (
  // level driven by the port register
  input wire logic [7:0] drive,
  // level seen back on the pins
  output logic [7:0] sense
);
  // inverting loads on the bits set in flip
  assign sense = drive ^ FLIP;
endmodule : pcfg_pin_load

// >>> pcfg_top_test.sv
// self-checking bench for the port 3 pin configuration block
// assumes pcfg_top, pcfg_pin_load and the bound checker are compiled first
`timescale 1ns/1ps
`include "pcfg_params.svh"
module pcfg_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] port1_pins_in = 8'h5a, port2_pins_in = 8'ha5;
  wire logic [7:0] port0_pins_in, port3_pins_in;
  logic [7:0] port0_value_out, port1_value_out, port2_value_out, port3_value_out;
  logic [20:0] port3_out_mode, em;
  logic [13:0] port3_in_mode, ei;
  wire logic [31:0] pv = {port3_value_out, port2_value_out, port1_value_out, port0_value_out};
  int n_mismatch = 0;
  int compares = 0;
  // 20 mhz clock
  always #25 aclk = ~aclk;
  pcfg_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port0_pins_in, .port1_pins_in, .port2_pins_in, .port3_pins_in,
    .port0_value_out, .port1_value_out, .port2_value_out, .port3_value_out, .port3_out_mode,
    .port3_in_mode);
  pcfg_pin_load #(.FLIP(8'h0f)) u_load0 (.drive(port0_value_out), .sense(port0_pins_in));
  pcfg_pin_load #(.FLIP(8'hf0)) u_load3 (.drive(port3_value_out), .sense(port3_pins_in));
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one write, both channels offered together, response compared
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    // byte address is four times the register index
    s_axi_awaddr <= {22'h0, a, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  // one read, data and response compared
  task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, ed});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    int g;
    logic [2:0] oc;
    logic [1:0] ic;
    em = 21'h0;
    ei = 14'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pv, 32'hffffffff);
    rd(`PCFG_OFF_P3CFG_IDX, `PCFG_CFG_RST, `PCFG_RESP_OKAY);
    // value registers write and pin read
    for (g = 0; g < 4; g++) begin
      wr(8'h80 + 8'(g * 16), 8'h30 + 8'(g), `PCFG_RESP_OKAY);
      chk(pv[8*g +: 8], 8'h30 + 8'(g));
      rd(8'h80 + 8'(g * 16), pv_pins(g), `PCFG_RESP_OKAY);
    end
    for (g = 0; g < 7; g++) begin
      oc = g[0] ? 3'h0 : 3'h3;
      ic = 2'(g + 1);
      wr(8'h8f, {oc, 2'b00, 3'(g)}, `PCFG_RESP_OKAY);
      wr(8'h8f, {1'b0, ic, 2'b10, 3'(g)}, `PCFG_RESP_OKAY);
      em[3*g +: 3] = oc;
      ei[2*g +: 2] = ic;
    end
    chk(port3_out_mode, em);
    chk(port3_in_mode, ei);
    wr(8'h8f, 8'h67, `PCFG_RESP_OKAY);
    wr(8'h8f, 8'h77, `PCFG_RESP_OKAY);
    // read pointer per pin and direction
    for (g = 0; g < 8; g++) begin
      wr(8'h8f, {3'h7, 2'b01, 3'(g)}, `PCFG_RESP_OKAY);
      rd(8'h8f, g < 7 ? {em[3*g +: 3], 5'h0} : 8'h0, `PCFG_RESP_OKAY);
      wr(8'h8f, {3'h7, 2'b11, 3'(g)}, `PCFG_RESP_OKAY);
      rd(8'h8f, g < 7 ? {1'b0, ei[2*g +: 2], 5'h0} : 8'h0, `PCFG_RESP_OKAY);
    end
    chk(port3_in_mode, ei);
    chk(port3_out_mode, em);
    // lane 0 strobe off: answered, nothing written
    s_axi_wstrb <= 4'he;
    wr(8'h80, 8'h77, `PCFG_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    chk(pv[7:0], 8'h30);
    wr(8'h84, 8'h00, `PCFG_RESP_SLVERR);
    rd(8'h84, 8'h00, `PCFG_RESP_SLVERR);
    chk(pv, 32'h33323130);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(port3_in_mode, 14'h0);
    chk(port3_out_mode, 21'h0);
    chk(pv, 32'hffffffff);
    rd(8'h8f, 8'h00, `PCFG_RESP_OKAY);
    final_report;
  end
  // pin levels expected back after the value writes
  function automatic logic [7:0] pv_pins(input int p);
    logic [31:0] t;
    t = 32'hc3a55a3f;
    return t[8*p +: 8];
  endfunction : pv_pins
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    final_report;
  end
endmodule : pcfg_top_test
